// >>> sbc_defs.vh
// Constants of the serial register access layer: addresses, masks, codes.
// Assumes inclusion by sbc_spi_regs.v and by the testbench; holds definitions, no logic.
//
// Behaviour
// - Frame bits six to zero carry the seven-bit register address.
// - Bit seven picks read or read-clear (status), read or write (config).
// - Frame bits fifteen to eight carry the eight data bits.
// - Access is per byte; the device never clears status bits on its own.
// - Config bits hold unless a register defines a hardware change.
// - In restart, sleep or fail-safe mode a received frame is discarded.
// - An addressed status register returns its content in the same frame.
// - Config reads return the old value; a write shows in a later frame.
// - Every answer carries an eight-bit summary, one bit per status register.
// - Summary bits 0-6 map to status 0x41-0x47, bit 7 to 0x4c.
// - A summary bit drops only when its whole status register is zero.
// - The wake level register takes no part in the summary.
// - Addresses 0x01 to 0x1e are config; bit seven decides write.
// - Addresses 0x41 to 0x7e are status; bit seven set clears the byte.
// - Wake level reports the live wake pin and ignores clears.
// - On a mode change the mode field takes the mode entered.
// - On sleep entry bus fields set on become wake-capable.
// - Secondary supply setting is accepted only in normal mode.
// - Input sampled on falling clock, output shifted on rising clock.
// - Clock count not 0 or 16, or clock high at select edges, flags error.
// - A forbidden mode request is ignored and sets the failure flag.
`ifndef SBC_DEFS_VH
`define SBC_DEFS_VH

// ****************************************************************
// Register addresses
// ****************************************************************
`define SBC_A_MODE   7'h01
`define SBC_A_HW     7'h02
`define SBC_A_WDOG   7'h03
`define SBC_A_BUSA   7'h04
`define SBC_A_BUSB   7'h05
`define SBC_A_WKA    7'h06
`define SBC_A_WKB    7'h07
`define SBC_A_PULL   7'h08
`define SBC_A_TIMER  7'h0c
`define SBC_A_SCR    7'h1e
`define SBC_A_SUP    7'h41
`define SBC_A_THERM  7'h42
`define SBC_A_DEV    7'h43
`define SBC_A_BFA    7'h44
`define SBC_A_BFB    7'h45
`define SBC_A_WSA    7'h46
`define SBC_A_WSB    7'h47
`define SBC_A_LEVEL  7'h48
`define SBC_A_SMPS   7'h4c
`define SBC_A_ID     7'h7e

// ****************************************************************
// Masks of implemented bits, entry 0 in the low byte
// ****************************************************************
`define SBC_CFG_WMASK  80'hff070301_44fbfbff_ffdf
`define SBC_STAT_MASK  64'hf70fb17e_67ff07fd
`define SBC_CFG_RESET  8'h00
`define SBC_STAT_RESET 8'h00

// ****************************************************************
// Field positions and codes
// ****************************************************************
`define SBC_MODE_NORMAL 2'h0
`define SBC_MODE_SLEEP  2'h1
`define SBC_MODE_STOP   2'h2
`define SBC_BUS_ON      2'h3
`define SBC_BUS_WAKE    2'h1
`define SBC_SPI_FAIL_BIT 1
`define SBC_DEV_IDX     2
`define SBC_FRAME_BITS  5'h10
`define SBC_CNT_SAT     5'h11
`define SBC_ADDR_DONE   5'h07
`define SBC_ID_VALUE    8'h5a

`endif

// >>> sbc_spi_host.sv
// Host model that sends frames on the serial link.
// Assumes core_clk at 10 ns; the link clock has a 160 ns period.
`timescale 1ns/10ps
module sbc_spi_host (
  input  wire core_clk,
  input  wire serial_out,
  output reg  sclk,
  output reg  chip_select_low,
  output reg  serial_in
);
  integer k;
  initial begin
    sclk = 1'b0;
    chip_select_low = 1'b1;
    serial_in = 1'b0;
  end
  task half;
    begin
      repeat (8) @(posedge core_clk);
    end
  endtask
  // Sends n clocks of tx, lowest bit first, and gathers the answer.
  task frame(input [15:0] tx, input [4:0] n, output [15:0] rx,
             output err);
    begin
      rx = 16'h0000;
      chip_select_low <= 1'b0;
      serial_in <= tx[0];
      half;
      err = serial_out;
      for (k = 0; k < n; k = k + 1) begin
        sclk <= 1'b1;
        if (k > 0)
          serial_in <= tx[k];
        half;
        sclk <= 1'b0;
        rx[k] = serial_out;
        half;
      end
      chip_select_low <= 1'b1;
      serial_in <= ~serial_in;
      half;
    end
  endtask
endmodule

// >>> sbc_spi_regs.v
// Serial register access layer: frame receiver, register file, summary.
// Assumes a slow serial clock from the master, sampled by core_clk, and
// mode levels and status set pulses from logic on core_clk.
`timescale 1ns/10ps
`include "sbc_defs.vh"

module sbc_spi_regs (
  input  wire        core_clk,
  input  wire        resetn,
  input  wire        sclk,
  input  wire        chip_select_low,
  input  wire        serial_in,
  output wire        serial_out,
  output wire        serial_out_oe,
  input  wire        wake_pin,
  input  wire        in_normal,
  input  wire        in_stop,
  input  wire        in_init,
  input  wire        in_restart,
  input  wire        in_sleep,
  input  wire        in_failsafe,
  input  wire        mode_entered,
  input  wire [1:0]  mode_entered_code,
  input  wire        sleep_entered,
  input  wire [63:0] status_set,
  output wire        mode_req,
  output wire [1:0]  mode_req_code,
  output wire        cmd_illegal,
  output wire [7:0]  mode_supply_control,
  output wire [7:0]  hardware_control,
  output wire [7:0]  watchdog_control,
  output wire [7:0]  bus_control_a,
  output wire [7:0]  bus_control_b,
  output wire [7:0]  wake_control_a,
  output wire [7:0]  wake_control_b,
  output wire [7:0]  wake_pull_control,
  output wire [7:0]  cyclic_timer_control,
  output wire [7:0]  system_scratch_control,
  output wire [7:0]  status_summary
);

  localparam [79:0] CFG_WM  = `SBC_CFG_WMASK;
  localparam [63:0] STAT_M  = `SBC_STAT_MASK;

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  reg        sclk_s1_r;
  reg        sclk_s2_r;
  reg        sclk_s3_r;
  reg        cs_s1_r;
  reg        cs_s2_r;
  reg        cs_s3_r;
  reg        sdi_s1_r;
  reg        sdi_s2_r;
  reg        wake_s1_r;
  reg        wake_s2_r;

  always @(posedge core_clk) begin
    if (!resetn) begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
      cs_s1_r   <= 1'b1;
      cs_s2_r   <= 1'b1;
      cs_s3_r   <= 1'b1;
      sdi_s1_r  <= 1'b0;
      sdi_s2_r  <= 1'b0;
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
    end else begin
      sclk_s1_r <= sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      cs_s1_r   <= chip_select_low;
      cs_s2_r   <= cs_s1_r;
      cs_s3_r   <= cs_s2_r;
      sdi_s1_r  <= serial_in;
      sdi_s2_r  <= sdi_s1_r;
      wake_s1_r <= wake_pin;
      wake_s2_r <= wake_s1_r;
    end
  end

  wire sclk_rise = sclk_s2_r & ~sclk_s3_r;
  wire sclk_fall = ~sclk_s2_r & sclk_s3_r;
  wire cs_fall   = ~cs_s2_r & cs_s3_r;
  wire cs_rise   = cs_s2_r & ~cs_s3_r;
  wire quiet     = in_restart | in_sleep | in_failsafe;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function [4:0] cfg_sel;
    input [6:0] a;
    begin
      if (a == `SBC_A_MODE) begin
        cfg_sel = 5'h10;
      end else if (a == `SBC_A_HW) begin
        cfg_sel = 5'h11;
      end else if (a == `SBC_A_WDOG) begin
        cfg_sel = 5'h12;
      end else if (a == `SBC_A_BUSA) begin
        cfg_sel = 5'h13;
      end else if (a == `SBC_A_BUSB) begin
        cfg_sel = 5'h14;
      end else if (a == `SBC_A_WKA) begin
        cfg_sel = 5'h15;
      end else if (a == `SBC_A_WKB) begin
        cfg_sel = 5'h16;
      end else if (a == `SBC_A_PULL) begin
        cfg_sel = 5'h17;
      end else if (a == `SBC_A_TIMER) begin
        cfg_sel = 5'h18;
      end else if (a == `SBC_A_SCR) begin
        cfg_sel = 5'h19;
      end else begin
        cfg_sel = 5'h00;
      end
    end
  endfunction

  function [3:0] stat_sel;
    input [6:0] a;
    begin
      if (a == `SBC_A_SUP) begin
        stat_sel = 4'h8;
      end else if (a == `SBC_A_THERM) begin
        stat_sel = 4'h9;
      end else if (a == `SBC_A_DEV) begin
        stat_sel = 4'ha;
      end else if (a == `SBC_A_BFA) begin
        stat_sel = 4'hb;
      end else if (a == `SBC_A_BFB) begin
        stat_sel = 4'hc;
      end else if (a == `SBC_A_WSA) begin
        stat_sel = 4'hd;
      end else if (a == `SBC_A_WSB) begin
        stat_sel = 4'he;
      end else if (a == `SBC_A_SMPS) begin
        stat_sel = 4'hf;
      end else begin
        stat_sel = 4'h0;
      end
    end
  endfunction

  function [1:0] to_wake;
    input [1:0] f;
    begin
      if (f == `SBC_BUS_ON) to_wake = `SBC_BUS_WAKE;
      else                  to_wake = f;
    end
  endfunction

  // ****************************************************************
  // Frame state
  // ****************************************************************
  reg  [15:0] rx_r;
  reg  [15:0] tx_r;
  reg  [4:0]  cnt_r;
  reg         out_bit_r;
  reg         oe_r;
  reg         err_r;
  reg         bad_r;
  reg         exec_r;
  reg  [79:0] cfg_r;
  reg  [63:0] stat_r;
  wire [79:0] cfg_nxt;
  wire [63:0] stat_nxt;
  wire [7:0]  sif;
  reg  [7:0]  rdata;

  wire [6:0] addr    = rx_r[6:0];
  wire       wr_bit  = rx_r[7];
  wire [7:0] wdata   = rx_r[15:8];
  wire [4:0] csel    = cfg_sel(addr);
  wire [3:0] ssel    = stat_sel(addr);
  wire [4:0] csel_rd = cfg_sel(rx_r[6:0]);
  wire [1:0] new_mode = wdata[7:6];

  // ****************************************************************
  // Read data select
  // ****************************************************************

  // Read data is picked once the address is complete.
  always @* begin
    rdata = 8'h00;
    if (csel_rd[4]) begin
      rdata = cfg_r[{csel_rd[3:0], 3'b000} +: 8];
    end else if (ssel[3]) begin
      rdata = stat_r[{ssel[2:0], 3'b000} +: 8];
    end else if (addr == `SBC_A_LEVEL) begin
      rdata = {7'h00, wake_s2_r};
    end else if (addr == `SBC_A_ID) begin
      rdata = `SBC_ID_VALUE;
    end
  end

  // ****************************************************************
  // Frame receiver and transmitter
  // ****************************************************************

  wire bad_end = bad_r | sclk_s2_r |
                 ((cnt_r != 5'h00) && (cnt_r != `SBC_FRAME_BITS));

  always @(posedge core_clk) begin
    if (!resetn) begin
      rx_r      <= 16'h0000;
      tx_r      <= 16'h0000;
      cnt_r     <= 5'h00;
      out_bit_r <= 1'b0;
      oe_r      <= 1'b0;
      err_r     <= 1'b0;
      bad_r     <= 1'b0;
      exec_r    <= 1'b0;
    end else begin
      exec_r <= 1'b0;
      oe_r   <= ~cs_s2_r;
      if (cs_fall) begin
        cnt_r     <= 5'h00;
        bad_r     <= sclk_s2_r;
        tx_r      <= {8'h00, sif};
        out_bit_r <= err_r;
      end else if (!cs_s2_r) begin
        if (sclk_rise) begin
          out_bit_r <= tx_r[0];
          tx_r      <= {1'b0, tx_r[15:1]};
        end
        if (sclk_fall) begin
          if (cnt_r < `SBC_FRAME_BITS) begin
            rx_r[cnt_r[3:0]] <= sdi_s2_r;
          end
          if (cnt_r != `SBC_CNT_SAT) begin
            cnt_r <= cnt_r + 5'h01;
          end
          if (cnt_r == `SBC_ADDR_DONE) begin
            tx_r[7:0] <= rdata;
          end
        end
      end
      if (cs_rise) begin
        if (bad_end) begin
          err_r <= 1'b1;
        end else if (cnt_r == `SBC_FRAME_BITS) begin
          err_r <= 1'b0;
        end
        exec_r <= ~bad_end & (cnt_r == `SBC_FRAME_BITS) & ~quiet;
      end
    end
  end

  assign serial_out    = out_bit_r;
  assign serial_out_oe = oe_r;

  // ****************************************************************
  // Command checks
  // ****************************************************************
  wire mode_wr = exec_r & wr_bit & (csel == 5'h10);
  wire no_wake = (cfg_r[31:24] == 8'h00) & (cfg_r[55:48] == 8'h00);
  wire illegal = mode_wr & (
                 (in_stop & (new_mode == `SBC_MODE_SLEEP)) |
                 (in_init & ((new_mode == `SBC_MODE_SLEEP) |
                             (new_mode == `SBC_MODE_STOP))) |
                 ((new_mode == `SBC_MODE_SLEEP) & no_wake));

  // ****************************************************************
  // Mode request outputs
  // ****************************************************************

  reg       mode_req_r;
  reg [1:0] mode_code_r;
  reg       illegal_r;

  always @(posedge core_clk) begin
    if (!resetn) begin
      mode_req_r  <= 1'b0;
      mode_code_r <= 2'h0;
      illegal_r   <= 1'b0;
    end else begin
      mode_req_r <= mode_wr & ~illegal;
      illegal_r  <= illegal;
      if (mode_wr & ~illegal) begin
        mode_code_r <= new_mode;
      end
    end
  end

  assign mode_req      = mode_req_r;
  assign mode_req_code = mode_code_r;
  assign cmd_illegal   = illegal_r;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < 10; i = i + 1) begin : g_cfg
      localparam [3:0] IDX = i;
      wire [7:0] old = cfg_r[i*8 +: 8];
      wire [7:0] wm  = CFG_WM[i*8 +: 8];
      wire hit = exec_r & wr_bit & (csel == {1'b1, IDX}) &
                 ~illegal;
      reg  [7:0] nx;
      always @* begin
        nx = old;
        if (hit) begin
          nx = wdata & wm;
          if (i == 0 && !in_normal) begin
            nx[4:3] = old[4:3];
          end
        end
        if (i == 0 && mode_entered) begin
          nx[7:6] = mode_entered_code;
        end
        if (i == 3 && sleep_entered) begin
          nx[4:3] = to_wake(nx[4:3]);
          nx[1:0] = to_wake(nx[1:0]);
        end
        if (i == 4 && sleep_entered) begin
          nx[7:6] = to_wake(nx[7:6]);
          nx[4:3] = to_wake(nx[4:3]);
          nx[1:0] = to_wake(nx[1:0]);
        end
      end
      assign cfg_nxt[i*8 +: 8] = nx;
    end
  endgenerate

  // ****************************************************************
  // Status registers and summary
  // ****************************************************************
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_stat
      localparam [2:0] IDX = i;
      wire [7:0] old = stat_r[i*8 +: 8];
      wire clr = exec_r & wr_bit & (ssel == {1'b1, IDX});
      wire [7:0] hw = status_set[i*8 +: 8];
      wire [7:0] fail = (i == `SBC_DEV_IDX) ?
                        {6'h00, illegal, 1'b0} : 8'h00;
      // A set arriving with the clear survives it.
      assign stat_nxt[i*8 +: 8] = ((clr ? 8'h00 : old) | hw | fail) &
                                  STAT_M[i*8 +: 8];
      assign sif[i] = |old;
    end
  endgenerate

  always @(posedge core_clk) begin
    if (!resetn) begin
      cfg_r  <= {10{`SBC_CFG_RESET}};
      stat_r <= {8{`SBC_STAT_RESET}};
    end else begin
      cfg_r  <= cfg_nxt;
      stat_r <= stat_nxt;
    end
  end

  // ****************************************************************
  // Register outputs
  // ****************************************************************

  assign status_summary         = sif;
  assign mode_supply_control    = cfg_r[7:0];
  assign hardware_control       = cfg_r[15:8];
  assign watchdog_control       = cfg_r[23:16];
  assign bus_control_a          = cfg_r[31:24];
  assign bus_control_b          = cfg_r[39:32];
  assign wake_control_a         = cfg_r[47:40];
  assign wake_control_b         = cfg_r[55:48];
  assign wake_pull_control      = cfg_r[63:56];
  assign cyclic_timer_control   = cfg_r[71:64];
  assign system_scratch_control = cfg_r[79:72];

endmodule

// >>> sbc_spi_regs_sva.sv
// Checker of the serial register layer, on top-level ports only.
// Assumes core_clk as the only clock and resetn synchronous, active low.
`timescale 1ns/10ps
module sbc_spi_regs_chk (
  input wire        core_clk,
  input wire        resetn,
  input wire        chip_select_low,
  input wire        serial_out_oe,
  input wire        in_normal,
  input wire        mode_entered,
  input wire [1:0]  mode_entered_code,
  input wire        sleep_entered,
  input wire [63:0] status_set,
  input wire        mode_req,
  input wire        cmd_illegal,
  input wire [7:0]  mode_supply_control,
  input wire [7:0]  bus_control_a,
  input wire [7:0]  status_summary
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  oe_idle_a: assert property (
    chip_select_low [*8] |-> !serial_out_oe) else $error("driven idle");
  oe_frame_a: assert property (
    $fell(chip_select_low) |-> ##[2:6] serial_out_oe) else $error("no drive");
  req_after_a: assert property (
    mode_req |-> chip_select_low && $past(chip_select_low, 2))
    else $error("request inside frame");
  illegal_flag_a: assert property (
    cmd_illegal |-> !mode_req ##[0:1] status_summary[2])
    else $error("forbidden request not flagged");
  cfg_hold_a: assert property (
    (!chip_select_low && !mode_entered && !sleep_entered) [*4] |=>
    $stable(mode_supply_control) && $stable(bus_control_a))
    else $error("config changed by itself");
  sum_rise_a: assert property (
    |(status_summary & ~$past(status_summary)) |->
    $past(|status_set) || cmd_illegal) else $error("summary set by itself");
  sum_drop_a: assert property (
    |($past(status_summary) & ~status_summary) |->
    chip_select_low && $past(chip_select_low, 3))
    else $error("summary dropped outside a clear");
  sum_map_a: assert property (
    |(status_set[63:56] & 8'hf7) |=> status_summary[7])
    else $error("summary bit 7 not set");
  mode_code_a: assert property (
    mode_entered |=> mode_supply_control[7:6] == $past(mode_entered_code))
    else $error("mode field not updated");
  sleep_bus_a: assert property (
    sleep_entered && bus_control_a[1:0] == 2'b11 |=>
    bus_control_a[1:0] == 2'b01) else $error("bus field not wake-capable");
  supply_keep_a: assert property (
    !in_normal |=> $stable(mode_supply_control[4:3]))
    else $error("supply setting changed out of normal");
  cover property (mode_req);
  cover property (cmd_illegal);
  cover property ($fell(chip_select_low));
endmodule
bind sbc_spi_regs sbc_spi_regs_chk chk (
  .core_clk (core_clk), .resetn (resetn),
  .chip_select_low (chip_select_low), .serial_out_oe (serial_out_oe),
  .in_normal (in_normal), .mode_entered (mode_entered),
  .mode_entered_code (mode_entered_code), .sleep_entered (sleep_entered),
  .status_set (status_set), .mode_req (mode_req),
  .cmd_illegal (cmd_illegal), .mode_supply_control (mode_supply_control),
  .bus_control_a (bus_control_a), .status_summary (status_summary)
);

// >>> sbc_spi_regs_tb.sv
// Testbench of the serial register layer, driven through the host model.
// Assumes sbc_defs.vh, sbc_spi_regs, sbc_spi_host and the bound checker.
`timescale 1ns/10ps
`include "sbc_defs.vh"
module sbc_spi_regs_tb;
  reg         core_clk = 1'b0;
  reg         resetn = 1'b0;
  reg         wake_pin = 1'b0;
  reg         in_normal = 1'b1;
  reg         in_stop = 1'b0;
  reg         in_init = 1'b0;
  reg  [2:0]  quiet = 3'h0;
  reg         mode_entered = 1'b0;
  reg  [1:0]  mode_entered_code = 2'h0;
  reg         sleep_entered = 1'b0;
  reg  [63:0] status_set = 64'h0;
  reg  [15:0] rx;
  reg         err;
  reg         saw_illegal = 1'b0;
  integer     err_total = 0;
  integer     n_checks = 0;
  integer     cycles = 0;
  integer     i;
  wire        sclk, chip_select_low, serial_in, serial_out, mode_req;
  wire        cmd_illegal;
  wire [1:0]  mode_req_code;
  reg  [1:0]  req_code = 2'h0;
  wire [79:0] cfg;
  wire [7:0]  status_summary;
  wire [79:0] cmask = `SBC_CFG_WMASK;
  wire [63:0] smask = `SBC_STAT_MASK;
  wire [69:0] cadr = {7'h1e, 7'h0c, 7'h08, 7'h07, 7'h06, 7'h05, 7'h04,
                      7'h03, 7'h02, 7'h01};
  wire [55:0] sadr = {7'h4c, 7'h47, 7'h46, 7'h45, 7'h44, 7'h43, 7'h42,
                      7'h41};
  sbc_spi_host host (.core_clk (core_clk), .serial_out (serial_out),
    .sclk (sclk), .chip_select_low (chip_select_low),
    .serial_in (serial_in));
  sbc_spi_regs dut (.core_clk (core_clk), .resetn (resetn), .sclk (sclk),
    .chip_select_low (chip_select_low), .serial_in (serial_in),
    .serial_out (serial_out), .serial_out_oe (), .wake_pin (wake_pin),
    .in_normal (in_normal), .in_stop (in_stop), .in_init (in_init),
    .in_restart (quiet[2]), .in_sleep (quiet[1]), .in_failsafe (quiet[0]),
    .mode_entered (mode_entered), .mode_entered_code (mode_entered_code),
    .sleep_entered (sleep_entered), .status_set (status_set),
    .mode_req (mode_req), .mode_req_code (mode_req_code),
    .cmd_illegal (cmd_illegal),
    .mode_supply_control (cfg[7:0]), .hardware_control (cfg[15:8]),
    .watchdog_control (cfg[23:16]), .bus_control_a (cfg[31:24]),
    .bus_control_b (cfg[39:32]), .wake_control_a (cfg[47:40]),
    .wake_control_b (cfg[55:48]), .wake_pull_control (cfg[63:56]),
    .cyclic_timer_control (cfg[71:64]),
    .system_scratch_control (cfg[79:72]), .status_summary (status_summary));
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cmd_illegal === 1'b1)
      saw_illegal <= 1'b1;
    if (mode_req === 1'b1)
      req_code <= mode_req_code;
    if (cycles == 60000) begin
      err_total = err_total + 1;
      print_verdict;
    end
  end
  task check(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task xfer(input [6:0] a, input wc, input [7:0] d);
    begin
      host.frame({d, wc, a}, 5'h10, rx, err);
    end
  endtask
  task pulse;
    begin
      @(posedge core_clk);
      mode_entered <= 1'b0;
      sleep_entered <= 1'b0;
      status_set <= 64'h0;
      @(posedge core_clk);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge core_clk);
    xfer(7'h7e, 1'b0, 8'h00);
    check(rx[15:8], `SBC_ID_VALUE);
    check(rx[7:0] | cfg[7:0], 8'h00);
    for (i = 0; i < 10; i = i + 1) begin
      xfer(cadr[7*i+:7], 1'b1, i == 0 ? 8'h1f : 8'hff);
      check(rx[15:8], 8'h00);
      xfer(cadr[7*i+:7], 1'b0, 8'h00);
      check(rx[15:8], (i == 0 ? 8'h1f : 8'hff) & cmask[8*i+:8]);
      check(cfg[8*i+:8], (i == 0 ? 8'h1f : 8'hff) & cmask[8*i+:8]);
    end
    xfer(7'h09, 1'b1, 8'hff);
    xfer(7'h09, 1'b0, 8'h00);
    check(rx[15:8], 8'h00);
    $display("done config");
    for (i = 0; i < 3; i = i + 1) begin
      {in_normal, quiet} <= {1'b0, 3'h1 << i};
      xfer(7'h1e, 1'b1, 8'h00);
      {in_normal, quiet} <= 4'h8;
      xfer(7'h1e, 1'b0, 8'h00);
      check(rx[15:8], 8'hff);
    end
    $display("done quiet");
    for (i = 0; i < 8; i = i + 1) begin
      status_set[8*i+:8] <= 8'hff;
      pulse;
      xfer(sadr[7*i+:7], 1'b1, 8'h00);
      check(rx[7:0], 8'h01 << i);
      check(rx[15:8], smask[8*i+:8]);
      xfer(sadr[7*i+:7], 1'b0, 8'h00);
      check(rx[15:8] | rx[7:0], 8'h00);
    end
    wake_pin <= 1'b1;
    xfer(7'h48, 1'b1, 8'h00);
    xfer(7'h48, 1'b0, 8'h00);
    check(rx[15:8], 8'h01);
    check(rx[7:0], 8'h00);
    $display("done status");
    host.frame({8'h00, 1'b1, 7'h1e}, 5'h08, rx, err);
    host.frame(16'h0000, 5'h00, rx, err);
    check({7'h0, err}, 8'h01);
    xfer(7'h1e, 1'b0, 8'h00);
    check({7'h0, err}, 8'h01);
    check(rx[15:8], 8'hff);
    xfer(7'h1e, 1'b0, 8'h00);
    check({7'h0, err}, 8'h00);
    $display("done framing");
    {in_normal, in_stop} <= 2'b01;
    xfer(7'h01, 1'b1, 8'h80);
    mode_entered_code <= 2'h2;
    mode_entered <= 1'b1;
    pulse;
    check(cfg[7:0], 8'h98);
    check({6'h00, req_code}, 8'h02);
    xfer(7'h01, 1'b1, 8'h40);
    xfer(7'h43, 1'b1, 8'h00);
    check({7'h0, saw_illegal}, 8'h01);
    check(rx[7:0], 8'h04);
    check(rx[15:8] & 8'h02, 8'h02);
    check(cfg[7:0], 8'h98);
    sleep_entered <= 1'b1;
    pulse;
    check(cfg[31:24] & 8'h1b, 8'h09);
    $display("done modes");
    print_verdict;
  end
endmodule
